// ==== hw/epb_pkg.sv ====
// package for the nonvolatile program and boot loader block
// assumes a classic wishbone slave with 32-bit data, byte addresses
package epb_pkg;

  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [7:0] ADDR_PROG_CTRL = 8'h1D; // register index
  localparam logic [7:0] ADDR_OPT_FIRST = 8'h20; // register index
  localparam logic [7:0] ADDR_OPT_SECOND = 8'h21; // register index
  localparam logic [7:0] ADDR_BOOT_CTRL = 8'h22; // register index
  localparam logic [7:0] ADDR_BOOT_STAT = 8'h23; // register index
  localparam logic [7:0] ADDR_PROG_ADDR = 8'h24; // register index
  localparam logic [7:0] ADDR_PROG_DATA = 8'h25; // register index
  localparam logic [7:0] ADDR_ARRAY_DATA = 8'h26; // register index

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int LATCH_POS = 1;
  localparam int PGM_POS = 0;
  localparam int WAITKEEP_POS = 1;
  localparam int WDOG_POS = 0;
  localparam logic [7:0] OPT2_MASK = 8'h03;

  // boot control bits
  localparam int BC_LAMP_PROG = 0;
  localparam int BC_LAMP_VERF = 1;
  localparam int BC_CNT_CLR = 2;
  localparam int BC_CNT_CLK = 3;
  localparam int BC_TX = 4;

  // ********************************************************
  // constants
  // ********************************************************
  localparam logic [7:0] PROG_CTRL_RESET = 8'h00;
  localparam logic [7:0] ERASED_VALUE = 8'h00;
  localparam logic [15:0] BOOT_ROM_FIRST = 16'h3F00;
  localparam logic [15:0] BOOT_ROM_LAST = 16'h3FEF;
  localparam int EXT_CNT_BITS = 14;

  typedef enum logic [1:0] {
    EPB_FN_PROGRAM = 2'h0,
    EPB_FN_VERIFY = 2'h1,
    EPB_FN_JUMP_RAM = 2'h2,
    EPB_FN_LOAD_RAM = 2'h3
  } epb_func_t;

  // ********************************************************
  // carriers
  // ********************************************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } epb_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } epb_wb_rsp_t;

  typedef struct packed {
    logic wr;
    logic [13:0] adr;
    logic [7:0] dat;
  } epb_cell_wr_t;

endpackage

// ==== hw/epb_top.sv ====
// program-control and boot loader pin logic for the on-chip nonvolatile array
// assumes synchronous pins, one 50 MHz clock, wishbone master from the cpu side
//
// Contract
// - boot mode needs test level and receive high
// - boot routine lives at 3F00 to 3FEF
// - two select pins choose the boot function
// - lamp pins drive program and verify lamps
// - device clocks and clears 14-bit address counter
// - transmit pin is TX, receive pin RX
// - programming only through control register 1D
// - programming allowed in user, boot, test modes
// - latch set captures next write, blocks reads
// - latch clear gives normal read path
// - voltage bit applies programming voltage
// - voltage bit needs latch set earlier
// - one write never sets both bits
// - erased cells and option bytes read zero
// - unimplemented option bits read zero
// - two option registers, second one active
// - wait-keep bit keeps driver ports in wait
// - watchdog enable bit enables watchdog
`timescale 1ns/10ps
`default_nettype none

module epb_top
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // register bus
  input wire epb_pkg::epb_wb_req_t wb_req_i,
  output epb_pkg::epb_wb_rsp_t wb_rsp_o,
  // boot entry pins
  input wire logic test_level_voltage_i,
  input wire logic serial_receive_boot_pin_i,
  input wire logic function_select_a_i,
  input wire logic function_select_b_i,
  // boot output pins
  output logic serial_transmit_pin_o,
  output logic ext_counter_clear_o,
  output logic ext_counter_clock_o,
  output logic verify_lamp_pin_o,
  output logic program_lamp_pin_o,
  // array side
  input wire logic [7:0] array_rdata_i,
  output logic program_voltage_o,
  output epb_pkg::epb_cell_wr_t cell_wr_o,
  output logic array_read_en_o,
  // wait mode input, option outputs and boot mode output
  input wire logic wait_mode_i,
  output logic driver_ports_wait_keep_o,
  output logic driver_ports_force_low_o,
  output logic watchdog_enable_o,
  output logic boot_mode_o
);

  // ********************************************************
  // bus decode
  // ********************************************************
  logic [7:0] idx;
  logic req;
  logic wr;
  logic ack_q;
  logic [31:0] rdat_q;

  // word index; the cell window uses the upper address range
  assign idx = wb_req_i.adr[9:2];
  assign req = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  assign wr = req & wb_req_i.we & wb_req_i.sel[0];

  // cell window: byte address bit 16 set selects array cells
  logic cell_sel;
  logic [13:0] cell_adr;
  assign cell_sel = wb_req_i.adr[16];
  assign cell_adr = wb_req_i.adr[15:2];

  // ********************************************************
  // state
  // ********************************************************
  logic latch_q;
  logic pgm_q;
  logic [7:0] opt1_q;
  logic [7:0] opt2_q;
  logic [4:0] boot_ctrl_q;
  logic boot_q;
  logic captured_q;
  logic [13:0] cap_adr_q;
  logic [7:0] cap_dat_q;
  logic [7:0] arr_q;
  logic rst_seen_q;
  logic [1:0] func_q;

  // programming control; latch and voltage bits
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      latch_q <= epb_pkg::PROG_CTRL_RESET[epb_pkg::LATCH_POS];
      pgm_q <= epb_pkg::PROG_CTRL_RESET[epb_pkg::PGM_POS];
    end
    else if (wr && !cell_sel && idx == epb_pkg::ADDR_PROG_CTRL)
    begin
      latch_q <= wb_req_i.dat[epb_pkg::LATCH_POS];
      // voltage only with a latch already set; a combined set loses it
      pgm_q <= wb_req_i.dat[epb_pkg::PGM_POS] & latch_q;
    end
  end

  // capture of the write that follows the latch set
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      captured_q <= 1'b0;
      cap_adr_q <= 14'h0000;
      cap_dat_q <= 8'h00;
    end
    else if (!latch_q)
      captured_q <= 1'b0;
    else if (wr && cell_sel && !captured_q && !pgm_q)
    begin
      captured_q <= 1'b1;
      cap_adr_q <= cell_adr;
      cap_dat_q <= wb_req_i.dat[7:0];
    end
  end

  // option bytes; only the second is written, through the control path only while latched
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      opt1_q <= epb_pkg::ERASED_VALUE;
      opt2_q <= epb_pkg::ERASED_VALUE;
    end
    else if (wr && !cell_sel && latch_q && !captured_q)
    begin
      // cells only move from erased zero to one, so or the data in
      if (idx == epb_pkg::ADDR_OPT_SECOND)
        opt2_q <= opt2_q | (wb_req_i.dat[7:0] & epb_pkg::OPT2_MASK);
    end
  end

  // boot entry caught on the first edge after reset release
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_seen_q <= 1'b0;
      boot_q <= 1'b0;
      func_q <= 2'h0;
    end
    else if (!rst_seen_q)
    begin
      rst_seen_q <= 1'b1;
      boot_q <= test_level_voltage_i & serial_receive_boot_pin_i;
      func_q <= {function_select_a_i, function_select_b_i};
    end
  end

  // boot pin control register, driven by the loader routine that runs from
  // the boot rom span BOOT_ROM_FIRST to BOOT_ROM_LAST
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      boot_ctrl_q <= 5'h10; // transmit idles high
    else if (wr && !cell_sel && idx == epb_pkg::ADDR_BOOT_CTRL)
      boot_ctrl_q <= wb_req_i.dat[4:0];
  end

  // ********************************************************
  // pins and array outputs
  // ********************************************************
  // pins only follow the loader while boot mode holds, idle otherwise
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      program_lamp_pin_o <= 1'b0;
      verify_lamp_pin_o <= 1'b0;
      ext_counter_clear_o <= 1'b0;
      ext_counter_clock_o <= 1'b0;
      serial_transmit_pin_o <= 1'b1;
      boot_mode_o <= 1'b0;
    end
    else
    begin
      program_lamp_pin_o <= boot_q & boot_ctrl_q[epb_pkg::BC_LAMP_PROG];
      verify_lamp_pin_o <= boot_q & boot_ctrl_q[epb_pkg::BC_LAMP_VERF];
      ext_counter_clear_o <= boot_q & boot_ctrl_q[epb_pkg::BC_CNT_CLR];
      ext_counter_clock_o <= boot_q & boot_ctrl_q[epb_pkg::BC_CNT_CLK];
      serial_transmit_pin_o <= ~boot_q | boot_ctrl_q[epb_pkg::BC_TX];
      boot_mode_o <= boot_q;
    end
  end

  // array strobes and voltage follow the control bits
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      program_voltage_o <= 1'b0;
      cell_wr_o <= '0;
      array_read_en_o <= 1'b0;
      arr_q <= 8'h00;
    end
    else
    begin
      program_voltage_o <= pgm_q;
      cell_wr_o.wr <= pgm_q & captured_q;
      cell_wr_o.adr <= cap_adr_q;
      cell_wr_o.dat <= cap_dat_q;
      array_read_en_o <= ~latch_q;
      // reads blocked while latched: the path shows erased zero
      arr_q <= latch_q ? epb_pkg::ERASED_VALUE : array_rdata_i;
    end
  end

  // options applied to driver ports and watchdog
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      driver_ports_wait_keep_o <= 1'b0;
      driver_ports_force_low_o <= 1'b0;
      watchdog_enable_o <= 1'b0;
    end
    else
    begin
      driver_ports_wait_keep_o <= opt2_q[epb_pkg::WAITKEEP_POS];
      driver_ports_force_low_o <= wait_mode_i & ~opt2_q[epb_pkg::WAITKEEP_POS];
      watchdog_enable_o <= opt2_q[epb_pkg::WDOG_POS];
    end
  end

  // ********************************************************
  // read mux and acknowledge
  // ********************************************************
  logic [31:0] rd_d;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (cell_sel)
      rd_d = {24'h000000, arr_q};
    else
    begin
      unique case (idx)
        epb_pkg::ADDR_PROG_CTRL: rd_d = {30'h0, latch_q, pgm_q};
        epb_pkg::ADDR_OPT_FIRST: rd_d = {24'h0, opt1_q};
        epb_pkg::ADDR_OPT_SECOND: rd_d = {24'h0, opt2_q};
        epb_pkg::ADDR_BOOT_CTRL: rd_d = {27'h0, boot_ctrl_q};
        epb_pkg::ADDR_BOOT_STAT: rd_d = {28'h0, captured_q, func_q, boot_q};
        epb_pkg::ADDR_PROG_ADDR: rd_d = {18'h0, cap_adr_q};
        epb_pkg::ADDR_PROG_DATA: rd_d = {24'h0, cap_dat_q};
        epb_pkg::ADDR_ARRAY_DATA: rd_d = {24'h0, arr_q};
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  // one-cycle ack for every address; unmapped reads give zero
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req;
      rdat_q <= rd_d;
    end
  end

  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = rdat_q;

endmodule

`default_nettype wire

// ==== tb/epb_checker.sv ====
// port assertions for the program and boot block
// assumes a bind onto epb_top from the bench top
`timescale 1ns/10ps
`default_nettype none
module epb_checker
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // bus and pins
  input wire epb_pkg::epb_wb_req_t wb_req_i,
  input wire epb_pkg::epb_wb_rsp_t wb_rsp_o,
  input wire logic wait_mode_i,
  input wire logic program_voltage_o,
  input wire epb_pkg::epb_cell_wr_t cell_wr_o,
  input wire logic array_read_en_o,
  input wire logic driver_ports_force_low_o,
  input wire logic boot_mode_o,
  input wire logic serial_transmit_pin_o,
  input wire logic program_lamp_pin_o,
  input wire logic verify_lamp_pin_o,
  input wire logic ext_counter_clock_o,
  input wire logic ext_counter_clear_o
);
  // ****************
  // port relations
  // ****************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  ack_one_cycle_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held too long");
  ack_answers_a: assert property ((wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack) |=> wb_rsp_o.ack)
    else $error("request not acked");
  volt_blocks_read_a: assert property (program_voltage_o |-> !array_read_en_o)
    else $error("read path open while programming");
  cell_needs_volt_a: assert property (cell_wr_o.wr |-> program_voltage_o)
    else $error("cell write without voltage");
  volt_after_latch_a: assert property ($rose(program_voltage_o) |-> !$past(array_read_en_o))
    else $error("voltage rose without latch");
  no_wait_low_a: assert property (!$past(wait_mode_i) |-> !driver_ports_force_low_o)
    else $error("ports forced low outside wait");
  boot_sticks_a: assert property (boot_mode_o |=> boot_mode_o)
    else $error("boot mode dropped");
  pins_idle_a: assert property (!boot_mode_o |-> !(program_lamp_pin_o || verify_lamp_pin_o
    || ext_counter_clock_o || ext_counter_clear_o))
    else $error("boot pins active outside boot");
  tx_idle_a: assert property (!boot_mode_o |-> serial_transmit_pin_o)
    else $error("transmit pin not idle");
endmodule
`default_nettype wire

// ==== tb/epb_ext_mem.sv ====
// external counter and array cells beside the block
// assumes the block's pins are synchronous to mclk_i
`timescale 1ns/10ps
`default_nettype none
module epb_ext_mem
(
  // clock and pins
  input wire logic mclk_i,
  input wire logic cnt_clk_i,
  input wire logic cnt_clr_i,
  input wire epb_pkg::epb_cell_wr_t cell_wr_i,
  input wire logic read_en_i,
  // results
  output logic [13:0] cnt_o,
  output logic [7:0] rdata_o
);
  // ****************
  // model
  // ****************
  logic [7:0] mem [0:16383];
  logic [7:0] junk_q = 8'h5A;
  // clear wins over the clock, as on a ripple counter
  always_ff @(posedge cnt_clk_i or posedge cnt_clr_i)
    if (cnt_clr_i) cnt_o <= 14'h0;
    else cnt_o <= cnt_o + 14'h1;
  // array starts erased before any program cycle
  initial foreach (mem[i]) mem[i] = epb_pkg::ERASED_VALUE;
  // image maps one to one onto cells
  always @(posedge mclk_i)
    if (cell_wr_i.wr) mem[cell_wr_i.adr] <= cell_wr_i.dat;
  // latched array gives no valid data, so show a moving pattern
  always @(posedge mclk_i) junk_q <= ~junk_q;
  assign rdata_o = !read_en_i ? junk_q : mem[cell_wr_i.adr];
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for epb_top
// assumes the checker and external memory model files are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ****************
  // signals
  // ****************
  logic mclk_i, rst_n_i, test_level_voltage_i, serial_receive_boot_pin_i;
  logic function_select_a_i, function_select_b_i, wait_mode_i, serial_transmit_pin_o;
  logic ext_counter_clear_o, ext_counter_clock_o, verify_lamp_pin_o, program_lamp_pin_o;
  logic program_voltage_o, array_read_en_o, driver_ports_wait_keep_o;
  logic driver_ports_force_low_o, watchdog_enable_o, boot_mode_o;
  logic [7:0] array_rdata_i, q;
  logic [13:0] cnt;
  epb_pkg::epb_wb_req_t wb_req_i;
  epb_pkg::epb_wb_rsp_t wb_rsp_o;
  epb_pkg::epb_cell_wr_t cell_wr_o;
  int mismatches, check_count;
  epb_top DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .test_level_voltage_i(test_level_voltage_i),
    .serial_receive_boot_pin_i(serial_receive_boot_pin_i),
    .function_select_a_i(function_select_a_i), .function_select_b_i(function_select_b_i),
    .serial_transmit_pin_o(serial_transmit_pin_o), .ext_counter_clear_o(ext_counter_clear_o),
    .ext_counter_clock_o(ext_counter_clock_o), .verify_lamp_pin_o(verify_lamp_pin_o),
    .program_lamp_pin_o(program_lamp_pin_o), .array_rdata_i(array_rdata_i),
    .program_voltage_o(program_voltage_o), .cell_wr_o(cell_wr_o),
    .array_read_en_o(array_read_en_o), .wait_mode_i(wait_mode_i),
    .driver_ports_wait_keep_o(driver_ports_wait_keep_o),
    .driver_ports_force_low_o(driver_ports_force_low_o),
    .watchdog_enable_o(watchdog_enable_o), .boot_mode_o(boot_mode_o));
  epb_ext_mem u_mem (.mclk_i(mclk_i), .cnt_clk_i(ext_counter_clock_o),
    .cnt_clr_i(ext_counter_clear_o), .cell_wr_i(cell_wr_o), .read_en_i(array_read_en_o),
    .cnt_o(cnt), .rdata_o(array_rdata_i));
  // ****************
  // tasks
  // ****************
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  // classic cycle: hold until the rising edge that samples ack high, take data there
  task automatic wb(input logic we, input logic [31:0] a, input logic [7:0] d);
    wb_req_i <= {1'b1, 1'b1, we, 4'hF, a, 24'h0, d};
    do @(posedge mclk_i); while (wb_rsp_o.ack !== 1'b1);
    q = wb_rsp_o.dat[7:0];
    wb_req_i <= '0;
    @(posedge mclk_i);
  endtask
  function automatic logic [31:0] ra(input logic [7:0] i);
    return {22'h0, i, 2'h0};
  endfunction
  task automatic rd(input string n, input logic [7:0] i, input logic [7:0] e);
    wb(1'b0, ra(i), 8'h0);
    chk(n, q, e);
  endtask
  task automatic do_reset(input logic [3:0] s);
    rst_n_i <= 1'b0;
    {test_level_voltage_i, serial_receive_boot_pin_i, function_select_a_i,
      function_select_b_i} <= s;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // straps land on the first edge, boot pin flops on the second; look after that
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic t_reset;
    rd("prog", epb_pkg::ADDR_PROG_CTRL, 8'h00);
    rd("opt1", epb_pkg::ADDR_OPT_FIRST, 8'h00);
    rd("opt2", epb_pkg::ADDR_OPT_SECOND, 8'h00);
    rd("unmapped", 8'h00, 8'h00);
    chk("forcelow", driver_ports_force_low_o, 1);
    chk("wdog", watchdog_enable_o, 0);
    wait_mode_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk("no wait", driver_ports_force_low_o, 0);
    wait_mode_i <= 1'b1;
  endtask
  // latch, data, voltage, clear, with the illegal orders tried first
  task automatic t_prog;
    wb(1'b1, ra(epb_pkg::ADDR_PROG_CTRL), 8'h01);
    rd("volt only", epb_pkg::ADDR_PROG_CTRL, 8'h00);
    wb(1'b1, ra(epb_pkg::ADDR_PROG_CTRL), 8'h03);
    rd("both", epb_pkg::ADDR_PROG_CTRL, 8'h02);
    chk("rden", array_read_en_o, 0);
    wb(1'b1, 32'h10554, 8'hA5);
    wb(1'b1, ra(epb_pkg::ADDR_PROG_CTRL), 8'h03);
    rd("volt", epb_pkg::ADDR_PROG_CTRL, 8'h03);
    chk("vpp", program_voltage_o, 1);
    chk("cell", cell_wr_o, {1'b1, 14'h155, 8'hA5});
    rd("capt", epb_pkg::ADDR_PROG_DATA, 8'hA5);
    wb(1'b1, ra(epb_pkg::ADDR_PROG_CTRL), 8'h00);
    chk("vpp off", program_voltage_o, 0);
    chk("rden on", array_read_en_o, 1);
    wb(1'b0, 32'h10554, 8'h0);
    chk("cell rd", q, 8'hA5);
  endtask
  // software programs the option byte before normal use
  task automatic t_opt;
    wb(1'b1, ra(epb_pkg::ADDR_PROG_CTRL), 8'h02);
    wb(1'b0, 32'h10554, 8'h0);
    chk("latched rd", q, 8'h00);
    wb(1'b1, ra(epb_pkg::ADDR_OPT_SECOND), 8'hFF);
    wb(1'b1, ra(epb_pkg::ADDR_PROG_CTRL), 8'h00);
    rd("opt2", epb_pkg::ADDR_OPT_SECOND, 8'h03);
    rd("opt1", epb_pkg::ADDR_OPT_FIRST, 8'h00);
    chk("wdog", watchdog_enable_o, 1);
    chk("keep", driver_ports_wait_keep_o, 1);
    chk("forcelow", driver_ports_force_low_o, 0);
  endtask
  task automatic t_boot;
    for (int f = 0; f < 4; f++)
    begin
      do_reset({2'b11, f[1:0]});
      chk("boot", boot_mode_o, 1);
      rd("func", epb_pkg::ADDR_BOOT_STAT, {5'h0, f[1:0], 1'b1});
    end
    do_reset(4'b1000);
    chk("no boot", boot_mode_o, 0);
    do_reset(4'b1100);
    wb(1'b1, ra(epb_pkg::ADDR_BOOT_CTRL), 8'h03);
    chk("lamps", {program_lamp_pin_o, verify_lamp_pin_o}, 2'b11);
    chk("tx", serial_transmit_pin_o, 0);
    wb(1'b1, ra(epb_pkg::ADDR_BOOT_CTRL), 8'h04);
    repeat (3)
    begin
      wb(1'b1, ra(epb_pkg::ADDR_BOOT_CTRL), 8'h08);
      wb(1'b1, ra(epb_pkg::ADDR_BOOT_CTRL), 8'h00);
    end
    chk("count", cnt, 14'h3);
  endtask
  task automatic test_done;
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ****************
  // run
  // ****************
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  initial
  begin
    mismatches = 0;
    check_count = 0;
    wb_req_i = '0;
    rst_n_i = 1'b0;
    wait_mode_i = 1'b1;
    {test_level_voltage_i, serial_receive_boot_pin_i} = 2'b00;
    {function_select_a_i, function_select_b_i} = 2'b00;
    @(posedge mclk_i);
    do_reset(4'h0);
    t_reset;
    t_prog;
    t_opt;
    t_boot;
    test_done;
  end
  // whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    mismatches++;
    test_done;
  end
endmodule
bind epb_top epb_checker u_chk (.mclk_i, .rst_n_i, .wb_req_i, .wb_rsp_o, .wait_mode_i,
  .program_voltage_o, .cell_wr_o, .array_read_en_o, .driver_ports_force_low_o, .boot_mode_o,
  .serial_transmit_pin_o, .program_lamp_pin_o, .verify_lamp_pin_o, .ext_counter_clock_o,
  .ext_counter_clear_o);
`default_nettype wire
